//--- idr_defines.svh
`ifndef IDR_DEFINES_SVH
`define IDR_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define IDR_OFF_CMD    8'h00
`define IDR_OFF_STAT   8'h04
`define IDR_OFF_ERR    8'h08
`define IDR_OFF_DATA   8'h0C
`define IDR_OFF_CYL    8'h10
`define IDR_OFF_HEAD   8'h14
`define IDR_OFF_SPT    8'h18
`define IDR_OFF_LONG   8'h1C
`define IDR_OFF_MULT   8'h20
`define IDR_OFF_CFG    8'h24
`define IDR_OFF_CAP    8'h28
`define IDR_OFF_STRWR  8'h2C

// ==========================================================
// Command codes
`define IDR_CMD_FMT    8'h50
`define IDR_CMD_IDENT  8'hEC

// ==========================================================
// Status and error bit positions
`define IDR_ST_BSY     7
`define IDR_ST_DEVICE_READY_FLAG    6
`define IDR_ST_DF      5
`define IDR_ST_DRQ     3
`define IDR_ST_ERR     0
`define IDR_ER_ABORTED_COMMAND_ERROR    2

// ==========================================================
// Configuration bits and their places in word 0
`define IDR_CFG_PKT    0
`define IDR_CFG_REM    1
`define IDR_CFG_FIX    2
`define IDR_W0_PKT     15
`define IDR_W0_REM     7
`define IDR_W0_FIX     6

// ==========================================================
// Reset values of the host-written parameters
`define IDR_MULT_RST   16'h0001
`define IDR_CFG_RST    3'h4

// ==========================================================
// Identification word indices
`define IDR_W_CFG      8'h00
`define IDR_W_CYL      8'h01
`define IDR_W_HEAD     8'h03
`define IDR_W_SPT      8'h06
`define IDR_W_SER_LO   8'h0A
`define IDR_W_SER_HI   8'h13
`define IDR_W_LONG     8'h16
`define IDR_W_FW_LO    8'h17
`define IDR_W_FW_HI    8'h1A
`define IDR_W_MOD_LO   8'h1B
`define IDR_W_MOD_HI   8'h2E
`define IDR_W_MULT     8'h2F
`define IDR_W_CAP_LO   8'h39
`define IDR_W_CAP_HI   8'h3A
`define IDR_W_LAST     8'hFF

// ==========================================================
// String store layout
`define IDR_STR_DEPTH  34
`define IDR_STR_FW     6'h0A
`define IDR_STR_MOD    6'h0E
`define IDR_STR_FILL   16'h2020

// ==========================================================
// Timing
`define IDR_CLK_NS     5
`define IDR_PREP_NS    100
`define IDR_PREP_CYC \
  ((`IDR_PREP_NS + `IDR_CLK_NS - 1) / `IDR_CLK_NS)

`endif

//--- idr_pkg.sv
package idr_pkg;

  // ==========================================================
  // Command engine states
  typedef enum logic [2:0] {
    IDR_IDLE = 3'b001,
    IDR_BUSY = 3'b010,
    IDR_XFER = 3'b100
  } idr_state_t;

endpackage : idr_pkg

//--- idr_strram.sv
`timescale 1ns/1ps
`include "idr_defines.svh"

module idr_strram #(
  parameter int DEPTH = `IDR_STR_DEPTH,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);

  logic [15:0] mem [DEPTH];

  // ==========================================================
  // Storage, filled with blanks at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= `IDR_STR_FILL;
      end
    end else if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  always_comb begin
    rdata = (int'(raddr) < DEPTH) ? mem[raddr] : 16'h0000;
  end

endmodule : idr_strram

//--- idr_top.sv
`timescale 1ns/1ps
`include "idr_defines.svh"

// How it works
// - Format-track command 50h ends with aborted-command error set.
// - Identify command ECh is supported, PIO data-in, no parameters.
// - Identify sets busy, prepares 256 words, then data request, interrupt.
// - Reserved bits and words of the block read zero.
// - Flag word bit n appears on data line n.
// - Numeric words put their MSB on line 15, LSB on line 0.
// - 32-bit values go low half first, high half second.
// - Strings pack two chars per word, earlier char on lines 15:8.
// - Word 0 bits 15, 7, 6: packet device, removable, fixed.
// - Words 1, 3, 6 hold cylinders, heads, sectors per track.
// - Words 10-19 serial, 23-26 firmware, 27-46 model strings.
// - Word 22 gives extra bytes for long read and write.
// - Word 47 low byte is max sectors per interrupt, high vendor.
// - Identify never reports an error.
module idr_top #(
  parameter int PREP_CYC = `IDR_PREP_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic INTRQ
);

  localparam int PREP_D = PREP_CYC;

  idr_pkg::idr_state_t state_r, state_nxt;
  logic [7:0] prep_r, prep_nxt;
  logic [7:0] widx_r, widx_nxt;
  logic intrq_r, intrq_nxt;
  logic err_r, err_nxt;
  logic aborted_command_error_r, aborted_command_error_nxt;
  logic [15:0] cyl_r, cyl_nxt;
  logic [15:0] head_r, head_nxt;
  logic [15:0] spt_r, spt_nxt;
  logic [15:0] long_r, long_nxt;
  logic [15:0] mult_r, mult_nxt;
  logic [2:0] cfg_r, cfg_nxt;
  logic [31:0] cap_r, cap_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic setup, acc, wr, rd;
  logic cmd_wr, stat_rd, pop;
  logic mapped;
  logic busy_flag, data_request_flag, device_ready_flag;
  logic device_fault_flag;
  logic [7:0] stat_byte;
  logic [15:0] word;
  logic [5:0] str_raddr;
  logic [15:0] str_rdata;
  logic str_we;

  // ==========================================================
  // Bus decode
  assign setup = PSEL & ~PENABLE;
  assign acc = PSEL & PENABLE & pready_r;
  assign wr = acc & PWRITE;
  assign rd = acc & ~PWRITE;
  assign cmd_wr = wr & (PADDR == `IDR_OFF_CMD);
  assign stat_rd = rd & (PADDR == `IDR_OFF_STAT);
  assign pop = rd & (PADDR == `IDR_OFF_DATA) & data_request_flag;
  assign str_we = wr & (PADDR == `IDR_OFF_STRWR);

  always_comb begin
    case (PADDR)
      `IDR_OFF_CMD, `IDR_OFF_STAT, `IDR_OFF_ERR, `IDR_OFF_DATA,
      `IDR_OFF_CYL, `IDR_OFF_HEAD, `IDR_OFF_SPT, `IDR_OFF_LONG,
      `IDR_OFF_MULT, `IDR_OFF_CFG, `IDR_OFF_CAP,
      `IDR_OFF_STRWR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Status flags
  assign busy_flag = (state_r == idr_pkg::IDR_BUSY);
  assign data_request_flag = (state_r == idr_pkg::IDR_XFER);
  assign device_ready_flag = ~busy_flag;
  assign device_fault_flag = 1'b0;

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`IDR_ST_BSY] = busy_flag;
    stat_byte[`IDR_ST_DEVICE_READY_FLAG] = device_ready_flag;
    stat_byte[`IDR_ST_DF] = device_fault_flag;
    stat_byte[`IDR_ST_DRQ] = data_request_flag;
    stat_byte[`IDR_ST_ERR] = err_r;
  end

  // ==========================================================
  // String store
  idr_strram #(
    .DEPTH(`IDR_STR_DEPTH),
    .AW(6)
  ) u_str (
    .clk(CLK),
    .rst(RST),
    .we(str_we),
    .waddr(PWDATA[21:16]),
    .wdata({PWDATA[7:0], PWDATA[15:8]}),
    .raddr(str_raddr),
    .rdata(str_rdata)
  );

  // ==========================================================
  // Identification word builder
  always_comb begin
    word = 16'h0000;
    str_raddr = 6'h00;
    if (widx_r == `IDR_W_CFG) begin
      word[`IDR_W0_PKT] = cfg_r[`IDR_CFG_PKT];
      word[`IDR_W0_REM] = cfg_r[`IDR_CFG_REM];
      word[`IDR_W0_FIX] = cfg_r[`IDR_CFG_FIX];
    end else if (widx_r == `IDR_W_CYL) begin
      word = cyl_r;
    end else if (widx_r == `IDR_W_HEAD) begin
      word = head_r;
    end else if (widx_r == `IDR_W_SPT) begin
      word = spt_r;
    end else if (widx_r == `IDR_W_LONG) begin
      word = long_r;
    end else if (widx_r == `IDR_W_MULT) begin
      word = mult_r;
    end else if (widx_r == `IDR_W_CAP_LO) begin
      word = cap_r[15:0];
    end else if (widx_r == `IDR_W_CAP_HI) begin
      word = cap_r[31:16];
    end else if (widx_r >= `IDR_W_SER_LO && widx_r <= `IDR_W_SER_HI) begin
      str_raddr = 6'(widx_r - `IDR_W_SER_LO);
      word = str_rdata;
    end else if (widx_r >= `IDR_W_FW_LO && widx_r <= `IDR_W_FW_HI) begin
      str_raddr = 6'(widx_r - `IDR_W_FW_LO) + `IDR_STR_FW;
      word = str_rdata;
    end else if (widx_r >= `IDR_W_MOD_LO && widx_r <= `IDR_W_MOD_HI) begin
      str_raddr = 6'(widx_r - `IDR_W_MOD_LO) + `IDR_STR_MOD;
      word = str_rdata;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    prep_nxt = prep_r;
    widx_nxt = widx_r;
    intrq_nxt = intrq_r;
    err_nxt = err_r;
    aborted_command_error_nxt = aborted_command_error_r;
    cyl_nxt = cyl_r;
    head_nxt = head_r;
    spt_nxt = spt_r;
    long_nxt = long_r;
    mult_nxt = mult_r;
    cfg_nxt = cfg_r;
    cap_nxt = cap_r;
    pready_nxt = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt = prdata_r;
    // Read data captured in setup phase
    if (setup) begin
      case (PADDR)
        `IDR_OFF_STAT: prdata_nxt = {24'h000000, stat_byte};
        `IDR_OFF_ERR: prdata_nxt = {29'h00000000, aborted_command_error_r, 2'h0};
        `IDR_OFF_DATA:
          prdata_nxt = data_request_flag ? {16'h0000, word} : 32'h0;
        `IDR_OFF_CYL: prdata_nxt = {16'h0000, cyl_r};
        `IDR_OFF_HEAD: prdata_nxt = {16'h0000, head_r};
        `IDR_OFF_SPT: prdata_nxt = {16'h0000, spt_r};
        `IDR_OFF_LONG: prdata_nxt = {16'h0000, long_r};
        `IDR_OFF_MULT: prdata_nxt = {16'h0000, mult_r};
        `IDR_OFF_CFG: prdata_nxt = {29'h00000000, cfg_r};
        `IDR_OFF_CAP: prdata_nxt = cap_r;
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (PADDR)
        `IDR_OFF_CYL: cyl_nxt = PWDATA[15:0];
        `IDR_OFF_HEAD: head_nxt = PWDATA[15:0];
        `IDR_OFF_SPT: spt_nxt = PWDATA[15:0];
        `IDR_OFF_LONG: long_nxt = PWDATA[15:0];
        `IDR_OFF_MULT: mult_nxt = PWDATA[15:0];
        `IDR_OFF_CFG: cfg_nxt = PWDATA[2:0];
        `IDR_OFF_CAP: cap_nxt = PWDATA;
        default: cfg_nxt = cfg_r;
      endcase
    end
    // Status read acknowledges; any set below wins
    if (stat_rd) begin
      intrq_nxt = 1'b0;
    end
    case (state_r)
      idr_pkg::IDR_IDLE: begin
        if (cmd_wr) begin
          if (PWDATA[7:0] == `IDR_CMD_IDENT) begin
            state_nxt = idr_pkg::IDR_BUSY;
            prep_nxt = 8'(PREP_CYC - 1);
            widx_nxt = 8'h00;
            err_nxt = 1'b0;
            aborted_command_error_nxt = 1'b0;
            intrq_nxt = 1'b0;
          end else begin
            // Format track and unknown codes abort
            err_nxt = 1'b1;
            aborted_command_error_nxt = 1'b1;
            intrq_nxt = 1'b1;
          end
        end
      end
      idr_pkg::IDR_BUSY: begin
        if (prep_r == 8'h00) begin
          state_nxt = idr_pkg::IDR_XFER;
          intrq_nxt = 1'b1;
        end else begin
          prep_nxt = prep_r - 8'h01;
        end
      end
      idr_pkg::IDR_XFER: begin
        if (pop) begin
          widx_nxt = widx_r + 8'h01;
          if (widx_r == `IDR_W_LAST) begin
            state_nxt = idr_pkg::IDR_IDLE;
          end
        end
      end
      default: state_nxt = idr_pkg::IDR_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= idr_pkg::IDR_IDLE;
      prep_r <= 8'h00;
      widx_r <= 8'h00;
      intrq_r <= 1'b0;
      err_r <= 1'b0;
      aborted_command_error_r <= 1'b0;
      cyl_r <= 16'h0000;
      head_r <= 16'h0000;
      spt_r <= 16'h0000;
      long_r <= 16'h0000;
      mult_r <= `IDR_MULT_RST;
      cfg_r <= `IDR_CFG_RST;
      cap_r <= 32'h00000000;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      prep_r <= prep_nxt;
      widx_r <= widx_nxt;
      intrq_r <= intrq_nxt;
      err_r <= err_nxt;
      aborted_command_error_r <= aborted_command_error_nxt;
      cyl_r <= cyl_nxt;
      head_r <= head_nxt;
      spt_r <= spt_nxt;
      long_r <= long_nxt;
      mult_r <= mult_nxt;
      cfg_r <= cfg_nxt;
      cap_r <= cap_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign INTRQ = intrq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_ident_start;
    cmd_wr && busy_flag == 1'b0 && !data_request_flag &&
      PWDATA[7:0] == `IDR_CMD_IDENT;
  endsequence

  sequence s_ready_irq;
    data_request_flag && !busy_flag && intrq_r;
  endsequence

  AST_FMT_ABORT: assert property (
    cmd_wr && state_r == idr_pkg::IDR_IDLE &&
      PWDATA[7:0] == `IDR_CMD_FMT
      |=> err_r && aborted_command_error_r && intrq_r && !busy_flag)
    else $error("format track did not abort");

  AST_IDENT_BUSY: assert property (
    s_ident_start |=> busy_flag && !err_r)
    else $error("identify did not go busy");

  AST_PREP_DONE: assert property (
    s_ident_start |-> ##[PREP_D:PREP_D] busy_flag ##1 s_ready_irq)
    else $error("identify data request late or missing");

  AST_RESERVED: assert property (
    (widx_r == 8'h02 || widx_r == 8'h30 || widx_r == 8'hFF)
      |-> word == 16'h0000)
    else $error("reserved word not zero");

  AST_WORD0: assert property (
    widx_r == `IDR_W_CFG |-> word[`IDR_W0_PKT] == cfg_r[`IDR_CFG_PKT]
      && word[`IDR_W0_REM] == cfg_r[`IDR_CFG_REM]
      && word[`IDR_W0_FIX] == cfg_r[`IDR_CFG_FIX]
      && word[5:0] == 6'h00)
    else $error("word 0 layout wrong");

  AST_CAP_ORDER: assert property (
    pop && widx_r == `IDR_W_CAP_LO
      |-> word == cap_r[15:0] ##1 word == cap_r[31:16])
    else $error("capacity halves out of order");

  AST_MODEL_MAP: assert property (
    widx_r == `IDR_W_MOD_LO |-> str_raddr == `IDR_STR_MOD &&
      word == str_rdata)
    else $error("model string misplaced");

  AST_NO_ERR: assert property (
    data_request_flag |-> !err_r && !aborted_command_error_r)
    else $error("identify reported an error");

  AST_LAST_WORD: assert property (
    pop && widx_r == `IDR_W_LAST
      |=> !data_request_flag && device_ready_flag && widx_r == 8'h00)
    else $error("did not idle after last word");

  AST_INT_HOLD: assert property (
    intrq_r && !stat_rd && !cmd_wr |=> intrq_r)
    else $error("interrupt dropped without status read");

endmodule : idr_top

//--- idr_host.sv
`timescale 1ns/1ps

module idr_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================================
  // Idle bus
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // ==========================================================
  // One APB transfer, request held until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r,
                    output logic e);
    xfer(1'b0, a, 32'h00000000, r, e);
  endtask : rd

  // Commands only once ready reads one; format only on request
  task automatic cmd(input logic [7:0] code);
    logic [31:0] s;
    logic e;
    s = 32'h00000000;
    while (s[6] !== 1'b1) begin
      rd(8'h04, s, e);
    end
    wr(8'h00, {24'h000000, code});
  endtask : cmd

  // One data register read
  task automatic read_data(output logic [31:0] r);
    logic e;
    rd(8'h0C, r, e);
  endtask : read_data

endmodule : idr_host

//--- test_identify_data_responder.sv
`timescale 1ns/1ps
`include "idr_defines.svh"

module test_identify_data_responder;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic intrq;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int seed;
  logic [15:0] ew;
  logic [15:0] cyl_v, head_v, spt_v, long_v, mult_v;
  logic [2:0] cfg_v;
  logic [31:0] cap_v;
  logic [15:0] str_v [34];
  logic [31:0] rv;
  logic ev;

  idr_top #(.PREP_CYC(12)) uut (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INTRQ(intrq));

  idr_host host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Verdict and checks
  task end_sim;
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wait_irq;
    while (intrq !== 1'b1) begin
      @(posedge clk);
    end
  endtask : wait_irq

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim;
    end
  end

  // ==========================================================
  // Expected identification word
  function automatic logic [15:0] exp_w(input int i);
    logic [15:0] w;
    w = 16'h0000;
    if (i == 0) begin
      w[15] = cfg_v[0];
      w[7] = cfg_v[1];
      w[6] = cfg_v[2];
    end
    else if (i == 1) w = cyl_v;
    else if (i == 3) w = head_v;
    else if (i == 6) w = spt_v;
    else if (i >= 10 && i <= 19) w = str_v[i-10];
    else if (i == 22) w = long_v;
    else if (i >= 23 && i <= 46) w = str_v[i-13];
    else if (i == 47) w = mult_v;
    else if (i == 57) w = cap_v[15:0];
    else if (i == 58) w = cap_v[31:16];
    return w;
  endfunction : exp_w

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h5BA1;
    rst = 1'b1;
    cyl_v = 16'($random(seed));
    head_v = 16'($random(seed));
    spt_v = 16'($random(seed));
    long_v = 16'($random(seed));
    mult_v = {8'($random(seed)), 8'hFF};
    cfg_v = 3'($random(seed));
    cap_v = $random(seed);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    host.rd(`IDR_OFF_STAT, rv, ev);
    chk(rv, 32'h00000040);
    chk({31'h0, intrq}, 32'h00000000);
    host.rd(`IDR_OFF_DATA, rv, ev);
    chk(rv, 32'h00000000);
    host.rd(8'h30, rv, ev);
    chk({31'h0, ev}, 32'h00000001);
    chk(rv, 32'h00000000);
    host.cmd(`IDR_CMD_FMT);
    wait_irq;
    repeat (4) @(posedge clk);
    chk({31'h0, intrq}, 32'h00000001);
    host.rd(`IDR_OFF_STAT, rv, ev);
    chk(rv, 32'h00000041);
    chk({31'h0, intrq}, 32'h00000000);
    host.rd(`IDR_OFF_ERR, rv, ev);
    chk(rv, 32'h00000004);
    host.wr(`IDR_OFF_CYL, {16'h0, cyl_v});
    host.wr(`IDR_OFF_HEAD, {16'h0, head_v});
    host.wr(`IDR_OFF_SPT, {16'h0, spt_v});
    host.wr(`IDR_OFF_LONG, {16'h0, long_v});
    host.wr(`IDR_OFF_MULT, {16'h0, mult_v});
    host.wr(`IDR_OFF_CFG, {29'h0, cfg_v});
    host.wr(`IDR_OFF_CAP, cap_v);
    for (int s = 0; s < 34; s++) begin
      str_v[s] = {2'b01, 6'($random(seed)), 2'b01, 6'($random(seed))};
      host.wr(`IDR_OFF_STRWR,
        {10'h0, 6'(s), str_v[s][7:0], str_v[s][15:8]});
    end
    host.cmd(`IDR_CMD_IDENT);
    host.rd(`IDR_OFF_STAT, rv, ev);
    chk(rv, 32'h00000080);
    host.wr(`IDR_OFF_CMD, {24'h0, `IDR_CMD_FMT});
    wait_irq;
    chk({31'h0, intrq}, 32'h00000001);
    host.rd(`IDR_OFF_STAT, rv, ev);
    chk(rv, 32'h00000048);
    chk({31'h0, intrq}, 32'h00000000);
    host.rd(`IDR_OFF_ERR, rv, ev);
    chk(rv, 32'h00000000);
    for (int i = 0; i < 256; i++) begin
      host.read_data(rv);
      ew = exp_w(i);
      chk(rv, {16'h0, ew});
    end
    host.rd(`IDR_OFF_STAT, rv, ev);
    chk(rv, 32'h00000040);
    host.rd(`IDR_OFF_DATA, rv, ev);
    chk(rv, 32'h00000000);
    end_sim;
  end

endmodule : test_identify_data_responder
